/* File: verilog/lsr_sensor_dev.sv */
// Sensor end: two-channel converter sequencer, result registers and
// serial slave. Raw counts come from an external front-end model;
// the serial clock and data arrive asynchronously from the host.
//
// Function
// - Convert visible_ir then ir channel each cycle
// - Results pass through staging buffer before register
// - Next conversion starts automatically after transfer
// - Standard range integrates 400 ms per channel
// - Extended range divides integration period by five
// - Eight-bit command register, written and read back
// - Respond only to slave address 0111001
// - Send Byte loads command register
// - Receive Byte returns command or selected result
// - 0x00 powers down, 0x03 powers up
// - 0x1D extended range, 0x18 standard range
// - 0x43 selects channel 0, 0x83 channel 1
// - Command register resets to 0x00
// - Range holds until power-down or new range
// - Reads after 0x03 return 0x03
// - Result: valid bit 7, chord 6:4, step 3:0
// - Valid set only after conversion since power-up
// - Zero code below limit, all ones on overflow
// - Eight chords of sixteen steps, ascending
// - Chord base counts from 16.5 times 2^C-1
// - Serial behaviour per SMBus 1.1 and 2.0
// - Host decodes count as base plus step times 2^C
// - Result stable until channel's next conversion or power-down, which clears valid bit 7
`timescale 1ns/100ps
module lsr_sensor_dev
  import lsr_pkg::*;
#(
  parameter int P_CONV_CYCLES = CONV_STD_CYCLES
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_SRST,
  input  wire logic        I_CE,
  lsr_smbus_if.device      bus,
  input  wire logic [11:0] I_VIS_COUNT,
  input  wire logic [11:0] I_IR_COUNT,
  output logic             O_CONVERTER_ENABLE,
  output logic             O_ACTIVE_CHANNEL,
  output logic             O_RANGE_EXTENDED
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic       scl_reg;
  logic       sda_reg;
  wire        scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
  wire        sda_agree = sda_sync_reg[1] == sda_sync_reg[2];
  wire        scl_next  = scl_agree ? scl_sync_reg[2] : scl_reg;
  wire        sda_next  = sda_agree ? sda_sync_reg[2] : sda_reg;
  wire        scl_rise  = scl_next & ~scl_reg;
  wire        scl_fall  = ~scl_next & scl_reg;
  wire        bus_start = scl_reg & scl_next & sda_reg & ~sda_next;
  wire        bus_stop  = scl_reg & scl_next & ~sda_reg & sda_next;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else if (I_CE) begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      scl_reg      <= scl_next;
      sda_reg      <= sda_next;
    end
  end

  // ----------------------------------------------------------------
  // Command register and decode
  // ----------------------------------------------------------------
  logic [7:0] command_control_reg;
  logic       power_reg;
  logic       ext_reg;
  logic [1:0] rd_sel_reg;
  logic       cmd_load;
  logic [7:0] cmd_byte;
  wire        power_next = cmd_load
                ? (cmd_byte == CMD_PWR_UP ? 1'b1
                   : cmd_byte == CMD_PWR_DN ? 1'b0 : power_reg)
                : power_reg;
  wire        ext_next = ~power_next ? 1'b0
                : cmd_load & cmd_byte == CMD_EXT ? 1'b1
                : cmd_load & cmd_byte == CMD_STD ? 1'b0 : ext_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      command_control_reg <= CMD_RESET;
      power_reg           <= 1'b0;
      ext_reg             <= 1'b0;
      rd_sel_reg          <= 2'h0;
    end else if (I_CE) begin
      if (cmd_load) begin
        command_control_reg <= cmd_byte;
        if (cmd_byte == CMD_PWR_UP)
          rd_sel_reg <= 2'h0;
        else if (cmd_byte == CMD_RD_CH0)
          rd_sel_reg <= 2'h1;
        else if (cmd_byte == CMD_RD_CH1)
          rd_sel_reg <= 2'h2;
      end
      power_reg <= power_next;
      ext_reg   <= ext_next;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  localparam logic [23:0] STD_LEN = 24'(P_CONV_CYCLES - 1);
  localparam logic [23:0] EXT_LEN = 24'(P_CONV_CYCLES / EXT_DIVISOR - 1);
  logic [23:0] timer_reg;
  logic        chan_reg;
  logic [6:0]  stage_reg;
  logic        stage_chan_reg;
  logic        pending_reg;
  logic [7:0]  result0_reg;
  logic [7:0]  result1_reg;
  wire  [23:0] conv_len = ext_reg ? EXT_LEN : STD_LEN;
  wire         conv_done = power_reg & (timer_reg >= conv_len);

  // Companding of the finished channel's raw count
  wire  [11:0] raw = chan_reg ? I_IR_COUNT : I_VIS_COUNT;
  wire  [7:0]  ge;
  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_chord
      assign ge[c] = raw >= CHORD_BASE[c];
    end
  endgenerate
  wire  [2:0]  chord   = 3'($countones(ge[7:1]));
  wire  [11:0] delta   = raw - CHORD_BASE[chord];
  wire  [11:0] steps   = delta >> chord;
  wire         over    = |steps[11:4];
  wire  [6:0]  code    = over ? CODE_OVERFLOW
                              : {chord, steps[3:0]};

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      timer_reg      <= 24'h000000;
      chan_reg       <= 1'b0;
      stage_reg      <= 7'h00;
      stage_chan_reg <= 1'b0;
      pending_reg    <= 1'b0;
      result0_reg    <= 8'h00;
      result1_reg    <= 8'h00;
    end else if (I_CE) begin
      if (!power_reg) begin
        timer_reg   <= 24'h000000;
        chan_reg    <= 1'b0;
        pending_reg <= 1'b0;
        result0_reg[VALID_BIT] <= 1'b0;
        result1_reg[VALID_BIT] <= 1'b0;
      end else begin
        if (conv_done) begin
          timer_reg      <= 24'h000000;
          chan_reg       <= ~chan_reg;
          stage_reg      <= code;
          stage_chan_reg <= chan_reg;
          pending_reg    <= 1'b1;
        end else begin
          timer_reg <= timer_reg + 24'h000001;
        end
        if (pending_reg) begin
          pending_reg <= 1'b0;
          if (stage_chan_reg)
            result1_reg <= {1'b1, stage_reg};
          else
            result0_reg <= {1'b1, stage_reg};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  lsr_dev_state_e state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       rw_reg;
  logic       pull_low_reg;
  wire  [7:0] shift_in  = {shift_reg[6:0], sda_next};
  wire        addr_hit  = shift_reg[7:1] == SLAVE_ADDR;
  wire  [7:0] tx_byte   = rd_sel_reg == 2'h1 ? result0_reg
                        : rd_sel_reg == 2'h2 ? result1_reg
                        : command_control_reg;
  wire        last_bit  = bit_cnt_reg == 4'h7;

  assign cmd_load = I_CE & scl_fall & (state_reg == DS_WR_ACK)
                  & ~pull_low_reg;
  assign cmd_byte = shift_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      state_reg    <= DS_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 4'h0;
      rw_reg       <= 1'b0;
      pull_low_reg <= 1'b0;
    end else if (I_CE) begin
      if (bus_start) begin
        state_reg    <= DS_ADDR;
        bit_cnt_reg  <= 4'h0;
        pull_low_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg    <= DS_IDLE;
        pull_low_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          DS_IDLE: begin
            pull_low_reg <= 1'b0;
          end
          DS_ADDR, DS_WR_BYTE: begin
            if (scl_rise) begin
              shift_reg   <= shift_in;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (last_bit)
                state_reg <= state_reg == DS_ADDR ? DS_ADDR_ACK
                                                  : DS_WR_ACK;
            end
          end
          DS_ADDR_ACK: begin
            if (scl_fall && !pull_low_reg) begin
              if (addr_hit) begin
                pull_low_reg <= 1'b1;
                rw_reg       <= shift_reg[0];
              end else begin
                state_reg <= DS_IDLE;
              end
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg    <= tx_byte;
                pull_low_reg <= ~tx_byte[7];
                state_reg    <= DS_RD_BYTE;
              end else begin
                pull_low_reg <= 1'b0;
                state_reg    <= DS_WR_BYTE;
              end
            end
          end
          DS_WR_ACK: begin
            if (scl_fall && !pull_low_reg) begin
              pull_low_reg <= 1'b1;
            end else if (scl_fall) begin
              pull_low_reg <= 1'b0;
              state_reg    <= DS_IDLE;
            end
          end
          DS_RD_BYTE: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg   <= {shift_reg[6:0], 1'b0};
              if (last_bit) begin
                pull_low_reg <= 1'b0;
                state_reg    <= DS_RD_ACK;
              end else begin
                pull_low_reg <= ~shift_reg[6];
              end
            end
          end
          DS_RD_ACK: begin
            if (scl_rise)
              state_reg <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.dev_sda_out      = 1'b0;
  assign bus.dev_sda_oe_n     = ~pull_low_reg;
  assign O_CONVERTER_ENABLE   = power_reg;
  assign O_ACTIVE_CHANNEL     = chan_reg;
  assign O_RANGE_EXTENDED     = ext_reg;

endmodule

/* File: include/lsr_pkg.sv */
// Constants shared by both ends of the light sensor serial link.
// Assumes a 40 MHz system clock on both ends.
package lsr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS           = 25;
  localparam int CONV_STD_MS      = 400;
  localparam int CONV_STD_CYCLES  = CONV_STD_MS * 1000000 / CLK_NS;
  localparam int EXT_DIVISOR      = 5;
  localparam int SCL_HALF_NS      = 5000;
  localparam int SCL_HALF_CYCLES  = SCL_HALF_NS / CLK_NS;
  localparam int SDA_SHIFT_CYCLES = SCL_HALF_CYCLES / 2;

  // ----------------------------------------------------------------
  // Serial address and commands
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR  = 7'h39;
  localparam logic [7:0] CMD_PWR_DN  = 8'h00;
  localparam logic [7:0] CMD_PWR_UP  = 8'h03;
  localparam logic [7:0] CMD_EXT     = 8'h1D;
  localparam logic [7:0] CMD_STD     = 8'h18;
  localparam logic [7:0] CMD_RD_CH0  = 8'h43;
  localparam logic [7:0] CMD_RD_CH1  = 8'h83;
  localparam logic [7:0] CMD_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Result register layout and companding
  // ----------------------------------------------------------------
  localparam int VALID_BIT  = 7;
  localparam int CHORD_LSB  = 4;
  localparam int STEP_LSB   = 0;
  localparam logic [6:0] CODE_OVERFLOW = 7'h7F;
  localparam logic [11:0] CHORD_BASE [8] = '{
    12'h000, 12'h010, 12'h031, 12'h073,
    12'h0F7, 12'h1FF, 12'h40F, 12'h82F
  };

  // ----------------------------------------------------------------
  // Host APB registers
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int DATA_LSB      = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  typedef enum {
    DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_WR_BYTE, DS_WR_ACK,
    DS_RD_BYTE, DS_RD_ACK
  } lsr_dev_state_e;

  typedef enum {
    HS_IDLE, HS_START, HS_BIT, HS_STOP
  } lsr_host_state_e;

endpackage

/* File: include/lsr_smbus_if.sv */
// Two-wire link between the sensor end and the host end.
// Open-drain data: each end only pulls low, the wire idles high.
`timescale 1ns/100ps
interface lsr_smbus_if;
  logic scl;
  logic sda;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;

  assign sda = (host_sda_oe_n | host_sda_out)
             & (dev_sda_oe_n | dev_sda_out);

  modport device (input scl, input sda,
                  output dev_sda_out, output dev_sda_oe_n);
  modport host (output scl, input sda,
                output host_sda_out, output host_sda_oe_n);
endinterface

/* File: verilog/lsr_smbus_host.sv */
// Host end: APB-controlled serial master issuing Send Byte and
// Receive Byte to the sensor. Serial clock is divided from I_CLOCK.
`timescale 1ns/100ps
module lsr_smbus_host
  import lsr_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_SRST,
  input  wire logic        I_CE,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  lsr_smbus_if.host        bus
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic        busy_reg;
  logic        nack_reg;
  logic [7:0]  rx_reg;
  logic [31:0] prdata_reg;
  logic        go;
  wire         hit_ctrl = I_PADDR == OFS_CTRL;
  wire         hit_stat = I_PADDR == OFS_STATUS;
  wire         setup    = I_PSEL & ~I_PENABLE;
  wire         wr_ctrl  = I_PSEL & I_PENABLE & I_PWRITE & hit_ctrl;
  wire  [31:0] rd_mux   = hit_stat
    ? {16'h0000, rx_reg, 6'h00, nack_reg, busy_reg} : 32'h00000000;

  assign go        = I_CE & wr_ctrl & I_PWDATA[CTRL_GO_BIT] & ~busy_reg;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~(hit_ctrl | hit_stat);
  assign O_PRDATA  = prdata_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST)
      prdata_reg <= 32'h00000000;
    else if (I_CE && setup)
      prdata_reg <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sda_sync_reg;
  logic       sda_reg;
  wire        sda_next = sda_sync_reg[1] == sda_sync_reg[2]
                         ? sda_sync_reg[2] : sda_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      sda_sync_reg <= 3'h7;
      sda_reg      <= 1'b1;
    end else if (I_CE) begin
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      sda_reg      <= sda_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial master sequencer
  // ----------------------------------------------------------------
  localparam logic [7:0] HALF_LAST = 8'(SCL_HALF_CYCLES - 1);
  localparam logic [7:0] SDA_POINT = 8'(SDA_SHIFT_CYCLES);
  lsr_host_state_e state_reg;
  logic [7:0] cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic       byte_reg;
  logic       read_reg;
  logic [7:0] tx_reg;
  logic       scl_reg;
  logic       low_reg;
  wire        tick     = cnt_reg == HALF_LAST;
  wire  [7:0] cur_byte = byte_reg ? tx_reg : {SLAVE_ADDR, read_reg};
  wire        listen   = bit_reg == 4'h8 ? ~(byte_reg & read_reg)
                                         : byte_reg & read_reg;
  wire        bit_low  = ~listen & ~(bit_reg[3] | cur_byte[3'(7 - bit_reg)]);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      state_reg <= HS_IDLE;
      cnt_reg   <= 8'h00;
      phase_reg <= 2'h0;
      bit_reg   <= 4'h0;
      byte_reg  <= 1'b0;
      read_reg  <= 1'b0;
      tx_reg    <= 8'h00;
      scl_reg   <= 1'b1;
      low_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      nack_reg  <= 1'b0;
      rx_reg    <= 8'h00;
    end else if (I_CE) begin
      cnt_reg <= (tick || state_reg == HS_IDLE) ? 8'h00 : cnt_reg + 8'h01;
      unique case (state_reg)
        HS_IDLE: begin
          if (go) begin
            read_reg  <= I_PWDATA[CTRL_READ_BIT];
            tx_reg    <= I_PWDATA[DATA_LSB +: 8];
            busy_reg  <= 1'b1;
            nack_reg  <= 1'b0;
            phase_reg <= 2'h0;
            state_reg <= HS_START;
          end
        end
        HS_START: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h0) begin
              low_reg <= 1'b1;
            end else begin
              scl_reg   <= 1'b0;
              phase_reg <= 2'h0;
              bit_reg   <= 4'h0;
              byte_reg  <= 1'b0;
              state_reg <= HS_BIT;
            end
          end
        end
        HS_BIT: begin
          if (phase_reg == 2'h0 && cnt_reg == SDA_POINT)
            low_reg <= bit_low;
          if (tick) begin
            phase_reg <= ~phase_reg[0] ? 2'h1 : 2'h0;
            scl_reg   <= ~phase_reg[0];
            if (phase_reg[0]) begin
              if (listen && bit_reg == 4'h8)
                nack_reg <= nack_reg | sda_reg;
              else if (listen)
                rx_reg <= {rx_reg[6:0], sda_reg};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h8) begin
                bit_reg <= 4'h0;
                if (byte_reg || sda_reg) begin
                  phase_reg <= 2'h0;
                  state_reg <= HS_STOP;
                end else begin
                  byte_reg <= 1'b1;
                end
              end
            end
          end
        end
        HS_STOP: begin
          if (phase_reg == 2'h0 && cnt_reg == SDA_POINT)
            low_reg <= 1'b1;
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h0) begin
              scl_reg <= 1'b1;
            end else if (phase_reg == 2'h1) begin
              low_reg <= 1'b0;
            end else begin
              busy_reg  <= 1'b0;
              state_reg <= HS_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign bus.scl           = scl_reg;
  assign bus.host_sda_out  = 1'b0;
  assign bus.host_sda_oe_n = ~low_reg;

endmodule

/* File: verif/lsr_link_assertions.sv */
// Checker for the serial link joining the host end to the sensor end.
// Assumes it sees the interface wires and the shared system clock.
`timescale 1ns/100ps
module lsr_link_assertions
  import lsr_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0] low_len_reg;
  logic [4:0] bit_num_reg;
  logic [7:0] addr_sh_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  wire        start_seen = scl & scl_d_reg & sda_d_reg & ~sda;
  wire        scl_rise   = scl & ~scl_d_reg;

  always_ff @(posedge I_CLOCK) begin
    scl_d_reg   <= scl;
    sda_d_reg   <= sda;
    low_len_reg <= (I_SRST | scl) ? 8'h00 : low_len_reg + 8'h01;
    if (I_SRST | start_seen) begin
      bit_num_reg <= 5'h00;
    end else if (scl_rise) begin
      bit_num_reg <= bit_num_reg + 5'h01;
    end
    if (scl_rise & (bit_num_reg < 5'h08)) begin
      addr_sh_reg <= {addr_sh_reg[6:0], sda};
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  AST_OPEN_DRAIN: assert property (!host_sda_out && !dev_sda_out)
    else $error("data line driven high");
  AST_RESET_IDLE: assert property ($fell(I_SRST) |-> scl && sda)
    else $error("link not idle after reset");
  AST_SCL_LOW_LEN: assert property ($rose(scl) |-> low_len_reg == 8'hC8)
    else $error("clock low phase length wrong");
  AST_START_HOLD: assert property (s_start |-> ##[199:201] $fell(scl))
    else $error("start hold time wrong");
  AST_STOP_SETUP: assert property (s_stop |->
      $past(scl, 199) && !$past(scl, 202))
    else $error("stop setup time wrong");
  AST_DEV_HOLD: assert property (
      scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("sensor changed data while clock high");
  AST_NO_EARLY_PULL: assert property (
      scl && $past(scl) && !dev_sda_oe_n |-> bit_num_reg >= 5'h09)
    else $error("sensor pulled data during address");
  AST_ADDR_ACK: assert property (
      scl && $past(scl) && bit_num_reg == 5'h09
      |-> dev_sda_oe_n == (addr_sh_reg[7:1] != SLAVE_ADDR))
    else $error("address acknowledge wrong");
  AST_HOST_YIELDS: assert property (
      scl |-> dev_sda_oe_n || host_sda_oe_n)
    else $error("both ends pulling data while clock high");
endmodule

/* File: verif/light_sensor_smbus_readout_bench.sv */
// Bench joining host end and sensor end over the serial link.
// Assumes the package and interface are compiled before this file.
`timescale 1ns/100ps
module light_sensor_smbus_readout_bench
  import lsr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int P_CONV = 13000;
  logic        clock     = 1'b0;
  logic        srst      = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [11:0] vis_count = 12'h12C;
  logic [11:0] ir_count  = 12'hFFF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_en;
  logic        act_chan;
  logic        range_ext;
  int          errors    = 0;
  int          checks    = 0;
  int          cyc       = 0;

  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  lsr_smbus_if i_lsr_smbus_if ();
  lsr_smbus_host i_lsr_smbus_host (
    .I_CLOCK(clock), .I_SRST(srst), .I_CE(1'b1), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .bus(i_lsr_smbus_if.host));
  lsr_sensor_dev #(.P_CONV_CYCLES(P_CONV)) i_lsr_sensor_dev (
    .I_CLOCK(clock), .I_SRST(srst), .I_CE(1'b1),
    .bus(i_lsr_smbus_if.device), .I_VIS_COUNT(vis_count),
    .I_IR_COUNT(ir_count), .O_CONVERTER_ENABLE(conv_en),
    .O_ACTIVE_CHANNEL(act_chan), .O_RANGE_EXTENDED(range_ext));
  lsr_link_assertions i_lsr_link_assertions (
    .I_CLOCK(clock), .I_SRST(srst), .scl(i_lsr_smbus_if.scl),
    .sda(i_lsr_smbus_if.sda),
    .host_sda_out(i_lsr_smbus_if.host_sda_out),
    .host_sda_oe_n(i_lsr_smbus_if.host_sda_oe_n),
    .dev_sda_out(i_lsr_smbus_if.dev_sda_out),
    .dev_sda_oe_n(i_lsr_smbus_if.dev_sda_oe_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic timeout(input string nm);
    errors++;
    $display("MISMATCH %s expected done seen timeout", nm);
    tally_and_finish();
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timeout("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic xfer(input logic rd, input logic [7:0] b,
                      output logic [7:0] got);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    apb(1'b1, OFS_CTRL, {16'h0000, b, 6'h00, rd, 1'b1}, r, e);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 5000);
    if (r[STAT_BUSY_BIT] !== 1'b0) timeout("busy");
    chk("nack", 32'h0, 32'(r[STAT_NACK_BIT]));
    got = r[DATA_LSB +: 8];
  endtask

  task automatic wait_chan(input logic v);
    int n;
    n = 0;
    while (act_chan !== v && n < 30000) begin
      @(posedge clock);
      n++;
    end
    if (act_chan !== v) timeout("channel");
  endtask

  function automatic logic [7:0] enc(input int n);
    int b;
    int k;
    int s;
    b = 0;
    k = 0;
    for (int c = 0; c < 8; c++)
      if (n >= (33 * ((1 << c) - 1)) / 2) begin
        b = (33 * ((1 << c) - 1)) / 2;
        k = c;
      end
    s = (n - b) >> k;
    enc = (s > 15) ? 8'h7F : {1'b0, k[2:0], s[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state();
    logic [31:0] r;
    logic        e;
    chk("enable", 32'h0, 32'(conv_en));
    chk("range", 32'h0, 32'(range_ext));
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("slverr", 32'h1, 32'(e));
    chk("unmapped", 32'h0, r);
    $display("test reset_state done");
  endtask

  task automatic t_power_up();
    logic [7:0] got;
    xfer(1'b0, CMD_PWR_UP, got);
    chk("enable", 32'h1, 32'(conv_en));
    chk("channel", 32'h0, 32'(act_chan));
    xfer(1'b1, 8'h00, got);
    chk("echo", 32'(CMD_PWR_UP), 32'(got));
    $display("test power_up done");
  endtask

  task automatic t_results();
    logic [7:0] got;
    logic       v;
    int         t;
    int         cnt;
    xfer(1'b0, CMD_RD_CH1, got);
    xfer(1'b1, 8'h00, got);
    chk("ch1_early", 32'h0, 32'(got[VALID_BIT]));
    v = act_chan;
    wait_chan(!v);
    t = cyc;
    wait_chan(v);
    chk("period", P_CONV, cyc - t);
    xfer(1'b1, 8'h00, got);
    chk("ch1", 32'hFF, 32'(got));
    vis_count <= 12'h7D0;
    xfer(1'b0, CMD_RD_CH0, got);
    xfer(1'b1, 8'h00, got);
    chk("ch0", 32'(enc(300) | 8'h80), 32'(got));
    cnt = CHORD_BASE[got[6:4]] + (int'(got[3:0]) << got[6:4]);
    chk("ch0_count", 32'h127, cnt);
    $display("test results done");
  endtask

  task automatic t_range();
    logic [7:0] got;
    logic       v;
    int         t;
    xfer(1'b0, CMD_EXT, got);
    chk("ext", 32'h1, 32'(range_ext));
    v = act_chan;
    wait_chan(!v);
    t = cyc;
    wait_chan(v);
    chk("ext_period", P_CONV / 5, cyc - t);
    xfer(1'b0, CMD_STD, got);
    chk("std", 32'h0, 32'(range_ext));
    xfer(1'b0, CMD_PWR_DN, got);
    chk("off", 32'h0, 32'(conv_en));
    $display("test range done");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset_state();
    t_power_up();
    t_results();
    t_range();
    tally_and_finish();
  end
endmodule
